//--- hw/tec_pkg.sv
// package for the t1 receive error counters: register indices, fields, timing
// assumes a 40 MHz system clock and 32-bit apb data
package tec_pkg;
   // register indices; the apb byte address is four times the index
   localparam logic [7:0] LINE_VIOLATION_COUNT_HIGH_IDX = 8'h23;
   localparam logic [7:0] LINE_VIOLATION_COUNT_LOW_IDX  = 8'h24;
   localparam logic [7:0] PATH_AND_SYNC_COUNT_HIGH_IDX  = 8'h25;
   localparam logic [7:0] PATH_VIOLATION_COUNT_LOW_IDX  = 8'h26;
   localparam logic [7:0] OUT_OF_SYNC_COUNT_LOW_IDX     = 8'h27;
   localparam logic [7:0] COUNT_CONTROL_IDX             = 8'h28;
   localparam logic [7:0] EVENT_STATUS_IDX              = 8'h29;
   localparam logic [7:0] EVENT_CLEAR_IDX               = 8'h2A;
   localparam logic [7:0] EVENT_ENABLE_IDX              = 8'h2B;

   // control register fields
   localparam int COUNT_EXCESS_ZEROS_POS       = 0;
   localparam int RX_ZERO_SUPPRESS_ENABLE_POS  = 1;
   localparam int RX_FRAMING_MODE_SELECT_POS   = 2;
   localparam int COUNT_SECONDARY_FBIT_POS     = 3;
   localparam int OOS_OR_FBIT_MODE_SELECT_POS  = 4;
   localparam int COUNT_INTERVAL_SELECT_POS    = 5;
   localparam int CONTROL_WIDTH                = 6;
   localparam logic [5:0] CONTROL_RESET        = 6'h00;

   // event status fields
   localparam int EVENT_SNAPSHOT_POS  = 0;
   localparam int EVENT_SYNC_LOST_POS = 1;
   localparam int EVENT_WIDTH         = 2;
   localparam logic [1:0] EVENT_RESET = 2'h0;

   // counter widths and zero-run lengths
   localparam int LINE_COUNT_WIDTH  = 16;
   localparam int PATH_COUNT_WIDTH  = 12;
   localparam int SYNC_COUNT_WIDTH  = 12;
   localparam logic [4:0] ZERO_RUN_PLAIN = 5'h10;
   localparam logic [4:0] ZERO_RUN_B8ZS  = 5'h08;

   // timing
   localparam int CLK_HZ            = 40_000_000;
   localparam int LONG_INTERVAL_MS  = 1000;
   localparam int SHORT_INTERVAL_MS = 42;
   localparam int LONG_INTERVAL_CYCLES  = (CLK_HZ / 1000) * LONG_INTERVAL_MS;
   localparam int SHORT_INTERVAL_CYCLES = (CLK_HZ / 1000) * SHORT_INTERVAL_MS;
   localparam int TIMER_WIDTH       = 26;
endpackage

//--- hw/tec_count_if.sv
// interface between the counter core and one saturating counter
// assumes a single clock domain
`timescale 1ns/100ps
`default_nettype none
interface tec_count_if #(parameter int WIDTH = 16);
   logic             count_inc;
   logic             restart;
   logic [WIDTH-1:0] snapshot;
   modport core (output count_inc, output restart, input snapshot);
   modport counter (input count_inc, input restart, output snapshot);
endinterface
`default_nettype wire

//--- hw/tec_sat_counter.sv
// one saturating event counter with a snapshot register
// assumes increments and restart come in on i_clk
`timescale 1ns/100ps
`default_nettype none
module tec_sat_counter #(
   parameter int WIDTH = 16
) (
   input  wire logic  i_clk,
   input  wire logic  i_reset_n,
   tec_count_if.counter port_if
);
   localparam logic [WIDTH-1:0] MAX_COUNT = {WIDTH{1'b1}};
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] snapshot_reg;

   // an event landing on the boundary opens the new interval
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count_reg <= '0;
      end else if (port_if.restart) begin
         count_reg <= {{(WIDTH-1){1'b0}}, port_if.count_inc}; // R12
      end else if (port_if.count_inc && count_reg != MAX_COUNT) begin
         count_reg <= count_reg + 1'b1; // R13
      end
   end

   // held until the next boundary so both bytes read coherently
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         snapshot_reg <= '0;
      end else if (port_if.restart) begin
         snapshot_reg <= count_reg; // R12 R14
      end
   end

   assign port_if.snapshot = snapshot_reg;
endmodule
`default_nettype wire

//--- hw/tec_error_counters.sv
// t1 receive error counters: line, path and multiframe counters with apb access
// assumes decoder and synchronizer event inputs are one-cycle pulses on i_clk
`timescale 1ns/100ps
`default_nettype none
// What this block does
// [R1] line violation count is 16 bits, high byte at 0x23, low byte at 0x24
// [R2] line violation counting never stops, not even during sync loss
// [R3] count bipolar violations plus 16 or 8 zero runs, skip b8zs code words
// [R4] in esf mode the path counter counts crc6 code word errors
// [R5] in d4 mode path counter counts ft errors, optionally fs errors too
// [R6] path counter halts while receive sync is lost
// [R7] path count msbs in low nibble of 0x25, low byte at 0x26
// [R8] in oos mode count out-of-sync multiframes, also during sync loss
// [R9] in f-bit mode count ft errors in d4, fps errors in esf
// [R10] in f-bit mode the multiframe counter halts during sync loss
// [R11] multiframe count msbs in high nibble of 0x25, low byte at 0x27
// [R12] snapshot all counts and restart each second, or every 42 ms
// [R13] counters saturate at maximum and never roll over
// [R14] register values stay stable between update boundaries
module tec_error_counters #(
   parameter int LONG_CYCLES  = tec_pkg::LONG_INTERVAL_CYCLES,
   parameter int SHORT_CYCLES = tec_pkg::SHORT_INTERVAL_CYCLES
) (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_bit_strobe,
   input  wire logic        i_bit_is_zero,
   input  wire logic        i_bipolar_violation,
   input  wire logic        i_b8zs_codeword,
   input  wire logic        i_crc6_error,
   input  wire logic        i_ft_error,
   input  wire logic        i_fs_error,
   input  wire logic        i_fps_error,
   input  wire logic        i_multiframe_strobe,
   input  wire logic        i_receive_sync_lost,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic             o_interval_tick,
   output logic             o_irq
);
   logic [tec_pkg::CONTROL_WIDTH-1:0] control_reg;
   logic [tec_pkg::EVENT_WIDTH-1:0]   event_status_reg;
   logic [tec_pkg::EVENT_WIDTH-1:0]   event_enable_reg;
   logic [tec_pkg::EVENT_WIDTH-1:0]   event_set;
   logic [tec_pkg::EVENT_WIDTH-1:0]   event_clear;
   logic [tec_pkg::TIMER_WIDTH-1:0]   timer_reg;
   logic [tec_pkg::TIMER_WIDTH-1:0]   timer_last;
   logic [4:0]                        zero_run_reg;
   logic [4:0]                        zero_run_limit;
   logic                              sync_lost_reg;
   logic                              tick;
   logic                              excess_zero_event;
   logic                              line_inc;
   logic                              path_inc;
   logic                              sync_inc;
   logic                              count_excess_zeros_bit;
   logic                              rx_zero_suppress_enable;
   logic                              rx_framing_mode_select;
   logic                              count_secondary_fbit_errors;
   logic                              oos_or_fbit_mode_select;
   logic                              count_interval_select;
   logic [7:0]                        reg_index;
   logic                              addr_aligned;
   logic                              addr_hit;
   logic                              setup_phase;
   logic                              write_access;
   logic [31:0]                       read_value;

   tec_count_if #(.WIDTH(tec_pkg::LINE_COUNT_WIDTH)) line_if ();
   tec_count_if #(.WIDTH(tec_pkg::PATH_COUNT_WIDTH)) path_if ();
   tec_count_if #(.WIDTH(tec_pkg::SYNC_COUNT_WIDTH)) sync_if ();

   assign count_excess_zeros_bit      = control_reg[tec_pkg::COUNT_EXCESS_ZEROS_POS];
   assign rx_zero_suppress_enable     = control_reg[tec_pkg::RX_ZERO_SUPPRESS_ENABLE_POS];
   assign rx_framing_mode_select      = control_reg[tec_pkg::RX_FRAMING_MODE_SELECT_POS];
   assign count_secondary_fbit_errors = control_reg[tec_pkg::COUNT_SECONDARY_FBIT_POS];
   assign oos_or_fbit_mode_select     = control_reg[tec_pkg::OOS_OR_FBIT_MODE_SELECT_POS];
   assign count_interval_select       = control_reg[tec_pkg::COUNT_INTERVAL_SELECT_POS];

   // ---------------- interval timer ----------------
   assign timer_last = count_interval_select ?
                       tec_pkg::TIMER_WIDTH'(SHORT_CYCLES - 1) :
                       tec_pkg::TIMER_WIDTH'(LONG_CYCLES - 1);
   assign tick = (timer_reg >= timer_last);

   // >= so that switching to the short interval mid-count ends at once
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         timer_reg <= '0;
      end else if (tick) begin
         timer_reg <= '0; // R12
      end else begin
         timer_reg <= timer_reg + 1'b1;
      end
   end

   assign o_interval_tick = tick;

   // ---------------- line code violations ----------------
   assign zero_run_limit = rx_zero_suppress_enable ?
                           tec_pkg::ZERO_RUN_B8ZS : tec_pkg::ZERO_RUN_PLAIN; // R3

   // run length stops at the limit so a long run counts once
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         zero_run_reg <= '0;
      end else if (i_bit_strobe) begin
         if (!i_bit_is_zero || i_b8zs_codeword && rx_zero_suppress_enable) begin
            zero_run_reg <= '0;
         end else if (zero_run_reg < zero_run_limit) begin
            zero_run_reg <= zero_run_reg + 1'b1;
         end
      end
   end

   assign excess_zero_event = count_excess_zeros_bit && i_bit_strobe && i_bit_is_zero &&
                              !(i_b8zs_codeword && rx_zero_suppress_enable) &&
                              (zero_run_reg == zero_run_limit - 5'h01); // R3
   // no sync-loss gating on this counter
   assign line_inc = (i_bipolar_violation &&
                      !(rx_zero_suppress_enable && i_b8zs_codeword)) ||
                     excess_zero_event; // R2 R3

   // ---------------- path code violations ----------------
   assign path_inc = !i_receive_sync_lost && // R6
                     (rx_framing_mode_select ? i_crc6_error : // R4
                      (i_ft_error || count_secondary_fbit_errors && i_fs_error)); // R5

   // ---------------- multiframe out of sync / f-bit errors ----------------
   assign sync_inc = oos_or_fbit_mode_select ?
                     (i_multiframe_strobe && i_receive_sync_lost) : // R8
                     (!i_receive_sync_lost && // R10
                      (rx_framing_mode_select ? i_fps_error : i_ft_error)); // R9

   assign line_if.count_inc = line_inc;
   assign line_if.restart   = tick;
   assign path_if.count_inc = path_inc;
   assign path_if.restart   = tick;
   assign sync_if.count_inc = sync_inc;
   assign sync_if.restart   = tick;

   tec_sat_counter #(.WIDTH(tec_pkg::LINE_COUNT_WIDTH)) u_line_count (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .port_if   (line_if)
   );
   tec_sat_counter #(.WIDTH(tec_pkg::PATH_COUNT_WIDTH)) u_path_count (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .port_if   (path_if)
   );
   tec_sat_counter #(.WIDTH(tec_pkg::SYNC_COUNT_WIDTH)) u_sync_count (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .port_if   (sync_if)
   );

   // ---------------- events and interrupt ----------------
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync_lost_reg <= 1'b0;
      end else begin
         sync_lost_reg <= i_receive_sync_lost;
      end
   end

   assign event_set[tec_pkg::EVENT_SNAPSHOT_POS]  = tick;
   assign event_set[tec_pkg::EVENT_SYNC_LOST_POS] = i_receive_sync_lost && !sync_lost_reg;
   assign event_clear = (write_access && reg_index == tec_pkg::EVENT_CLEAR_IDX) ?
                        i_pwdata[tec_pkg::EVENT_WIDTH-1:0] : '0;

   // set wins over a clear in the same cycle
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         event_status_reg <= tec_pkg::EVENT_RESET;
      end else begin
         event_status_reg <= (event_status_reg & ~event_clear) | event_set;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         event_enable_reg <= tec_pkg::EVENT_RESET;
      end else if (write_access && reg_index == tec_pkg::EVENT_ENABLE_IDX) begin
         event_enable_reg <= i_pwdata[tec_pkg::EVENT_WIDTH-1:0];
      end
   end

   assign o_irq = |(event_status_reg & event_enable_reg);

   // ---------------- apb slave ----------------
   assign reg_index    = {2'b00, i_paddr[7:2]};
   assign addr_aligned = (i_paddr[1:0] == 2'b00);
   assign addr_hit     = addr_aligned &&
                         reg_index >= tec_pkg::LINE_VIOLATION_COUNT_HIGH_IDX &&
                         reg_index <= tec_pkg::EVENT_ENABLE_IDX;
   assign setup_phase  = i_psel && !i_penable;
   assign write_access = i_psel && i_penable && i_pwrite && addr_hit;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         control_reg <= tec_pkg::CONTROL_RESET;
      end else if (write_access && reg_index == tec_pkg::COUNT_CONTROL_IDX) begin
         control_reg <= i_pwdata[tec_pkg::CONTROL_WIDTH-1:0];
      end
   end

   always_comb begin
      read_value = 32'h0000_0000;
      case (reg_index)
         tec_pkg::LINE_VIOLATION_COUNT_HIGH_IDX: read_value[7:0] = line_if.snapshot[15:8]; // R1
         tec_pkg::LINE_VIOLATION_COUNT_LOW_IDX:  read_value[7:0] = line_if.snapshot[7:0]; // R1
         tec_pkg::PATH_AND_SYNC_COUNT_HIGH_IDX:
            read_value[7:0] = {sync_if.snapshot[11:8], path_if.snapshot[11:8]}; // R7 R11
         tec_pkg::PATH_VIOLATION_COUNT_LOW_IDX:  read_value[7:0] = path_if.snapshot[7:0]; // R7
         tec_pkg::OUT_OF_SYNC_COUNT_LOW_IDX:     read_value[7:0] = sync_if.snapshot[7:0]; // R11
         tec_pkg::COUNT_CONTROL_IDX:
            read_value[tec_pkg::CONTROL_WIDTH-1:0] = control_reg;
         tec_pkg::EVENT_STATUS_IDX:
            read_value[tec_pkg::EVENT_WIDTH-1:0] = event_status_reg;
         tec_pkg::EVENT_ENABLE_IDX:
            read_value[tec_pkg::EVENT_WIDTH-1:0] = event_enable_reg;
         default: read_value = 32'h0000_0000;
      endcase
   end

   // read data latched in the setup cycle; a snapshot landing in the
   // access cycle then cannot tear the word being returned
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_prdata <= 32'h0000_0000;
      end else if (setup_phase && !i_pwrite) begin
         o_prdata <= (addr_hit ? read_value : 32'h0000_0000); // R14
      end
   end

   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel && i_penable && !addr_hit;
endmodule
`default_nettype wire

//--- test/tec_error_counters_monitor.sv
// port checker for the receive error counter block
// assumes apb answers with zero wait states, one clock domain
`timescale 1ns/100ps
`default_nettype none
module tec_error_counters_monitor #(
   parameter int LONG_CYCLES  = 200,
   parameter int SHORT_CYCLES = 50
) (
   input wire logic        i_clk,
   input wire logic        i_reset_n,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        o_interval_tick,
   input wire logic        o_irq
);
   logic [31:0] gap_reg;
   logic        acc;
   logic        cnt_addr;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   assign acc = i_psel && i_penable;
   assign cnt_addr = i_paddr inside {8'h8C, 8'h90, 8'h94, 8'h98, 8'h9C};
   // cycles since reset or the last boundary, mirrors the interval timer
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gap_reg <= 32'h0;
      end else begin
         gap_reg <= o_interval_tick ? 32'h0 : gap_reg + 32'h1;
      end
   end
   AST_TICK_GAP: assert property (o_interval_tick |-> gap_reg >= SHORT_CYCLES - 1)
      else $error("interval boundary came too early");
   AST_TICK_DUE: assert property (!o_interval_tick |-> gap_reg < LONG_CYCLES - 1)
      else $error("interval boundary overdue");
   AST_TICK_PULSE: assert property (o_interval_tick |=> !o_interval_tick)
      else $error("boundary pulse longer than one cycle");
   AST_PREADY: assert property (o_pready)
      else $error("ready low");
   // a refused write leaves the last read data alone, so only reads see zero
   AST_SLVERR_BAD: assert property (acc && i_paddr[1:0] != 2'h0
      |-> o_pslverr && (i_pwrite || o_prdata == 32'h0))
      else $error("misaligned access not refused");
   AST_SLVERR_MAP: assert property (acc && cnt_addr |-> !o_pslverr)
      else $error("counter register refused");
   AST_SLVERR_IDLE: assert property (!acc |-> !o_pslverr)
      else $error("error outside access phase");
   AST_PRDATA_HOLD: assert property (!(i_psel && !i_penable && !i_pwrite)
      |=> $stable(o_prdata))
      else $error("read data changed without a read");
   AST_BYTE_WIDE: assert property (acc && !i_pwrite && cnt_addr |-> o_prdata[31:8] == 24'h0)
      else $error("counter register wider than a byte");
   AST_IRQ_MASK: assert property (acc && i_pwrite && i_paddr == 8'hAC && i_pwdata[1:0] == 2'h0
      |=> !o_irq)
      else $error("interrupt not masked");
   COV_TICK: cover property (o_interval_tick);
   COV_ERR: cover property (o_pslverr);
   COV_IRQ: cover property ($rose(o_irq));
endmodule
bind tec_error_counters tec_error_counters_monitor #(
   .LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) mon_inst (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_interval_tick(o_interval_tick),
   .o_irq(o_irq));
`default_nettype wire

//--- test/tec_apb_host.sv
// host processor model: apb master issuing one transfer per call
// assumes the slave answers at some edge with pready high
`timescale 1ns/100ps
`default_nettype none
module tec_apb_host (
   input  wire logic        i_clk,
   input  wire logic [31:0] i_prdata,
   input  wire logic        i_pready,
   input  wire logic        i_pslverr,
   output logic             o_psel,
   output logic             o_penable,
   output logic             o_pwrite,
   output logic [7:0]       o_paddr,
   output logic [31:0]      o_pwdata
);
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 8'h00;
      o_pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge i_clk);
      o_psel <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_clk);
      o_penable <= 1'b1;
      do @(posedge i_clk); while (i_pready !== 1'b1);
      q = i_prdata;
      e = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      // released data is not left looking valid
      o_pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the receive error counters
// assumes short timer parameters so that saturation fits in one interval
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        i_clk;
   logic        i_reset_n;
   logic        sync_lost;
   logic [8:0]  ev;
   logic        psel, penable, pwrite, pready, pslverr, tick, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   int          n_fail, checks_done, cycles;

   tec_apb_host tec_apb_host_inst (.i_clk(i_clk), .i_prdata(prdata), .i_pready(pready),
      .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
      .o_paddr(paddr), .o_pwdata(pwdata));
   tec_error_counters #(.LONG_CYCLES(9000), .SHORT_CYCLES(100)) tec_error_counters_inst (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_bit_strobe(ev[7]), .i_bit_is_zero(ev[8]),
      .i_bipolar_violation(ev[0]), .i_b8zs_codeword(ev[6]), .i_crc6_error(ev[1]),
      .i_ft_error(ev[2]), .i_fs_error(ev[3]), .i_fps_error(ev[4]),
      .i_multiframe_strobe(ev[5]), .i_receive_sync_lost(sync_lost), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_interval_tick(tick),
      .o_irq(irq));

   always #12.5 i_clk = ~i_clk;

   task automatic final_report();
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
         n_fail++;
      end
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp,
                      input logic experr);
      logic [31:0] q;
      logic        e;
      tec_apb_host_inst.xfer(1'b0, a, 32'h0, q, e);
      chk(nm, exp, q);
      chk({nm, " error"}, {31'h0, experr}, {31'h0, e});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      tec_apb_host_inst.xfer(1'b1, a, d, q, e);
   endtask
   task automatic wait_tick();
      do @(posedge i_clk); while (tick !== 1'b1);
   endtask
   // ft and fs errors sit in different frames, so m2 lets a test drive them in separate cycles
   task automatic burst(input logic [8:0] m, input int n, input logic [8:0] m2 = 9'h0);
      repeat (n) begin
         @(posedge i_clk);
         ev <= m;
         @(posedge i_clk);
         ev <= m2;
      end
      @(posedge i_clk);
      ev <= 9'h0;
   endtask
   // one whole interval of events, then the snapshot is read back
   task automatic measure(input logic [5:0] c, input logic lost, input logic [8:0] m,
                          input int n, input logic [15:0] el, input logic [11:0] ep,
                          input logic [11:0] es, input logic [8:0] m2 = 9'h0);
      wr(8'hA0, {26'h0, c});
      sync_lost <= lost;
      wait_tick();
      burst(m, n, m2);
      wait_tick();
      rdc("line high", 8'h8C, {24'h0, el[15:8]}, 1'b0);
      rdc("line low", 8'h90, {24'h0, el[7:0]}, 1'b0);
      rdc("shared high", 8'h94, {24'h0, es[11:8], ep[11:8]}, 1'b0);
      rdc("path low", 8'h98, {24'h0, ep[7:0]}, 1'b0);
      rdc("sync low", 8'h9C, {24'h0, es[7:0]}, 1'b0);
   endtask

   task automatic t_reset();
      rdc("line high", 8'h8C, 32'h0, 1'b0);
      rdc("control", 8'hA0, 32'h0, 1'b0);
      wr(8'h8C, 32'hFF);
      rdc("read only", 8'h8C, 32'h0, 1'b0);
      rdc("misaligned", 8'h8D, 32'h0, 1'b1);
      rdc("unmapped", 8'hFC, 32'h0, 1'b1);
   endtask
   task automatic t_irq();
      wr(8'hA0, 32'h20);
      wr(8'hAC, 32'h1);
      wait_tick();
      #1 chk("irq raised", 32'h1, {31'h0, irq});
      rdc("status", 8'hA4, 32'h1, 1'b0);
      wr(8'hAC, 32'h0);
      #1 chk("irq masked", 32'h0, {31'h0, irq});
      wr(8'hAC, 32'h1);
      wr(8'hA8, 32'h1);
      #1 chk("irq cleared", 32'h0, {31'h0, irq});
      rdc("status cleared", 8'hA4, 32'h0, 1'b0);
   endtask
   task automatic t_line();
      measure(6'h22, 1'b0, 9'h041, 5, 16'h0, 12'h0, 12'h0);
      burst(9'h080, 1);
      measure(6'h21, 1'b0, 9'h180, 16, 16'h1, 12'h0, 12'h0);
      burst(9'h080, 1);
      measure(6'h23, 1'b0, 9'h180, 8, 16'h1, 12'h0, 12'h0);
   endtask
   task automatic t_path();
      measure(6'h20, 1'b0, 9'h00D, 5, 16'h5, 12'h5, 12'h5);
      measure(6'h28, 1'b0, 9'h004, 6, 16'h0, 12'hC, 12'h6, 9'h008);
      measure(6'h24, 1'b0, 9'h016, 7, 16'h0, 12'h7, 12'h7);
   endtask
   task automatic t_sync();
      measure(6'h30, 1'b1, 9'h025, 4, 16'h4, 12'h0, 12'h4);
      rdc("status sync onset", 8'hA4, 32'h3, 1'b0);
      measure(6'h20, 1'b1, 9'h005, 3, 16'h3, 12'h0, 12'h0);
   endtask
   task automatic t_sat();
      measure(6'h00, 1'b0, 9'h005, 4100, 16'h1004, 12'hFFF, 12'hFFF);
   endtask

   initial begin
      i_clk = 1'b0;
      i_reset_n = 1'b0;
      sync_lost = 1'b0;
      ev = 9'h0;
      n_fail = 0;
      checks_done = 0;
      cycles = 0;
      repeat (6) @(posedge i_clk);
      i_reset_n <= 1'b1;
      t_reset();
      t_irq();
      t_line();
      t_path();
      t_sync();
      t_sat();
      final_report();
   end
endmodule
`default_nettype wire
